/* common/bcdcal_pkg.sv */
// Purpose: constants and types shared by the bcd calendar core
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: time and date words use the same layout in shadow and live copies
package bcdcal_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_TIME = 8'h00;
	localparam logic [7:0] ADDR_DATE = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_ISR = 8'h0c;
	localparam logic [7:0] ADDR_PRER = 8'h10;
	localparam logic [7:0] ADDR_WPR = 8'h24;
	localparam logic [7:0] ADDR_SSR = 8'h28;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_HOUR12_BIT = 6;
	localparam int CTRL_CKSEL_LSB = 8;
	localparam int CTRL_ADD1H_BIT = 16;
	localparam int CTRL_SUB1H_BIT = 17;
	localparam int ISR_ACTIVE_BIT = 6;
	localparam int ISR_INIT_BIT = 7;
	localparam int PRER_ASYNC_LSB = 16;
	localparam int TIME_W = 23;
	localparam int DATE_W = 24;
	// ****************************************
	// keys, reset values, encodings
	// ****************************************
	localparam logic [7:0] KEY_FIRST = 8'hca;
	localparam logic [7:0] KEY_SECOND = 8'h53;
	localparam logic [7:0] KEY_RELOCK = 8'hff;
	localparam logic [6:0] RST_ASYNC_DIV = 7'h7f;
	localparam logic [14:0] RST_SYNC_DIV = 15'h00ff;
	localparam logic [22:0] RST_TIME = 23'h000000;
	localparam logic [23:0] RST_DATE = 24'h002101;
	localparam logic [1:0] CKSEL_NONE = 2'h0;
	localparam logic [1:0] CKSEL_CRYSTAL = 2'h1;
	localparam logic [1:0] CKSEL_INT_OSC = 2'h2;
	localparam logic [1:0] CKSEL_EXT_DIV = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// timing, in rtc kernel clock edges
	// ****************************************
	localparam logic [2:0] ENTER_EDGES = 3'h2;
	localparam logic [2:0] EXIT_EDGES = 3'h4;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_ENTER = 4'h2,
		ST_INIT = 4'h4,
		ST_EXIT = 4'h8
	} bcdcal_init_st_t;
	typedef enum logic [2:0] {
		KEY_LOCKED = 3'h1,
		KEY_HALF = 3'h2,
		KEY_OPEN = 3'h4
	} bcdcal_key_st_t;
endpackage

/* dv/tb_bcdcal_top.sv */
// Purpose: self-checking bench for the bcd calendar core
// Assumes: rtc sources toggle far below aclk
// Notes: dividers cut to 1/0 so seconds roll within a few cycles
`timescale 1ns/1ns
module tb_bcdcal_top;
	import bcdcal_pkg::*;
	// ********
	// signals
	// ********
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, calendar_tick, init_active_flag;
	logic low_speed_crystal, low_speed_internal_osc, divided_high_speed_clock;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int err_total, comparisons, cyc, tick_cnt, n, t;
	// ticks in 240 cycles per select code, dividers 1/0
	int tick_exp [4] = '{0, 15, 10, 12};

	bcdcal_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_speed_crystal,
		.low_speed_internal_osc, .divided_high_speed_clock, .calendar_tick,
		.init_active_flag);

	// ********
	// clocks and watchdog
	// ********
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// three unrelated rtc rates: 8, 12 and 10 aclk periods
	initial
	begin
		low_speed_crystal = 1'b0;
		forever #160 low_speed_crystal = ~low_speed_crystal;
	end
	initial
	begin
		low_speed_internal_osc = 1'b0;
		forever #240 low_speed_internal_osc = ~low_speed_internal_osc;
	end
	initial
	begin
		divided_high_speed_clock = 1'b0;
		forever #200 divided_high_speed_clock = ~divided_high_speed_clock;
	end
	always @(posedge aclk)
	begin
		cyc++;
		if (calendar_tick === 1'b1)
			tick_cnt++;
		if (cyc == 30000)
		begin
			err_total++;
			complete_run;
		end
	end

	// ********
	// tasks
	// ********
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_total++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				s_axi_bready <= 1'b0;
				rsp = s_axi_bresp;
			end
		end
		while (s_axi_bready);
	endtask

	// masked read compare
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				s_axi_rready <= 1'b0;
				rv = s_axi_rdata;
				rsp = s_axi_rresp;
			end
		end
		while (s_axi_rready);
		chk(rv & m, e);
	endtask

	// waits for the init flag (0) or a tick (1)
	task wait_for(input int which);
		n = 0;
		while ((which ? calendar_tick : init_active_flag) !== 1'b1 && n < 300)
		begin
			@(posedge aclk);
			n++;
		end
		chk(n < 300, 1'b1);
	endtask

	task complete_run;
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ********
	// tests
	// ********
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hf;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_PRER, 32'h007f00ff);
		rd(ADDR_TIME, 32'h00000000);
		rd(ADDR_DATE, 32'h00002101);
		rd(ADDR_CTRL, 32'h00000100);
		$display("test reset values done");
		wr(ADDR_CTRL, 32'h00000140);
		chk(32'(rsp), 32'(RESP_OKAY));
		rd(ADDR_CTRL, 32'h00000100);
		wr(ADDR_WPR, 32'h000000ca);
		wr(ADDR_WPR, 32'h00000053);
		wr(ADDR_CTRL, 32'h00000140);
		rd(ADDR_CTRL, 32'h00000140);
		wr(ADDR_WPR, 32'h000000ff);
		wr(ADDR_CTRL, 32'h00000100);
		rd(ADDR_CTRL, 32'h00000140);
		wr(ADDR_WPR, 32'h000000ca);
		wr(ADDR_WPR, 32'h00000053);
		wr(ADDR_CTRL, 32'h00000100);
		$display("test key protection done");
		wr(ADDR_TIME, 32'h00235959);
		rd(ADDR_TIME, 32'h00000000);
		wr(ADDR_ISR, 32'h00000080);
		chk(init_active_flag, 1'b0);
		wait_for(0);
		chk(n >= 4 && n <= 30, 1'b1);
		rd(ADDR_ISR, 32'h000000c0);
		// sync value first, then async
		wr(ADDR_PRER, 32'h007f0000);
		wr(ADDR_PRER, 32'h00010000);
		rd(ADDR_PRER, 32'h00010000);
		wr(ADDR_TIME, 32'h00235959);
		wr(ADDR_DATE, 32'h00012228);
		rd(ADDR_TIME, 32'h00235959);
		rd(ADDR_DATE, 32'h00012228);
		$display("test init entry done");
		t = cyc;
		wr(ADDR_ISR, 32'h00000000);
		rd(ADDR_TIME, 32'h00000000);
		wait_for(1);
		chk(cyc - t >= 30 && cyc - t <= 90, 1'b1);
		rd(ADDR_TIME, 32'h00000000);
		rd(ADDR_DATE, 32'h00014301);
		chk(init_active_flag, 1'b0);
		$display("test rollover done");
		wait_for(1);
		wr(ADDR_CTRL, 32'h00010100);
		rd(ADDR_TIME, 32'h00010000, 32'h003f0000);
		wr(ADDR_CTRL, 32'h00020100);
		rd(ADDR_TIME, 32'h00000000, 32'h003f0000);
		wr(ADDR_SSR, 32'h00001234);
		rd(ADDR_SSR, 32'h00000000);
		$display("test hour step and sub-second done");
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL, 32'(i) << 8);
			repeat (8) @(posedge aclk);
			t = tick_cnt;
			repeat (240) @(posedge aclk);
			chk(tick_cnt - t + 1 >= tick_exp[i] && tick_cnt - t <= tick_exp[i] + 1, 1'b1);
		end
		$display("test clock select done");
		rd(8'h30, 32'h00000000);
		chk(32'(rsp), 32'(RESP_SLVERR));
		wr(8'h30, 32'h00000001);
		chk(32'(rsp), 32'(RESP_SLVERR));
		$display("test unmapped done");
		complete_run;
	end
endmodule

/* hw/bcdcal_counter.sv */
// Purpose: live bcd time and date counter with daylight-saving steps
// Assumes: tick is a one-cycle pulse, load has priority over tick
// Notes: weekday runs 1..7, year 00..99
`timescale 1ns/1ns
module bcdcal_counter
	import bcdcal_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic load,
	input wire logic [bcdcal_pkg::TIME_W-1:0] load_time,
	input wire logic [bcdcal_pkg::DATE_W-1:0] load_date,
	input wire logic fmt12,
	input wire logic hour_inc,
	input wire logic hour_dec,
	output logic [bcdcal_pkg::TIME_W-1:0] live_time,
	output logic [bcdcal_pkg::DATE_W-1:0] live_date
);
	import bcdcal_pkg::*;

	logic [7:0] sec_r, min_r, hr_r, day_r, mon_r, yr_r;
	logic [7:0] sec_nxt, min_nxt, hr_nxt, day_nxt, mon_nxt, yr_nxt;
	logic [2:0] wd_r, wd_nxt;
	logic pm_r, pm_nxt;
	logic last_hour;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] bcd_dec(input logic [7:0] v);
		if (v[3:0] == 4'h0)
			return {v[7:4] - 4'h1, 4'h9};
		return {v[7:4], v[3:0] - 4'h1};
	endfunction

	// leap test straight on bcd digits, year 00 counts as leap
	function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		if (m == 8'h02)
			return leap ? 8'h29 : 8'h28;
		if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
			return 8'h30;
		return 8'h31;
	endfunction

	assign last_hour = fmt12 ? (hr_r == 8'h11 && pm_r) : (hr_r == 8'h23);

	always_comb
	begin
		sec_nxt = sec_r;
		min_nxt = min_r;
		hr_nxt = hr_r;
		pm_nxt = pm_r;
		wd_nxt = wd_r;
		day_nxt = day_r;
		mon_nxt = mon_r;
		yr_nxt = yr_r;
		if (tick)
		begin
			sec_nxt = (sec_r == 8'h59) ? 8'h00 : bcd_inc(sec_r);
			if (sec_r == 8'h59)
			begin
				min_nxt = (min_r == 8'h59) ? 8'h00 : bcd_inc(min_r);
				if (min_r == 8'h59)
				begin
					// 12-hour order is 12,1..11 with pm toggling at 11->12
					if (!fmt12)
						hr_nxt = (hr_r == 8'h23) ? 8'h00 : bcd_inc(hr_r);
					else if (hr_r == 8'h11)
					begin
						hr_nxt = 8'h12;
						pm_nxt = ~pm_r;
					end
					else
						hr_nxt = (hr_r == 8'h12) ? 8'h01 : bcd_inc(hr_r);
					if (last_hour)
					begin
						wd_nxt = (wd_r == 3'h7) ? 3'h1 : wd_r + 3'h1;
						day_nxt = (day_r == month_len(mon_r, yr_r)) ? 8'h01 : bcd_inc(day_r);
						if (day_r == month_len(mon_r, yr_r))
						begin
							mon_nxt = (mon_r == 8'h12) ? 8'h01 : bcd_inc(mon_r);
							if (mon_r == 8'h12)
								yr_nxt = (yr_r == 8'h99) ? 8'h00 : bcd_inc(yr_r);
						end
					end
				end
			end
		end
		else if (hour_inc && !last_hour)
		begin
			// step the hour alone, never crossing midnight
			if (fmt12 && hr_r == 8'h11)
			begin
				hr_nxt = 8'h12;
				pm_nxt = 1'b1;
			end
			else if (fmt12 && hr_r == 8'h12)
				hr_nxt = 8'h01;
			else
				hr_nxt = bcd_inc(hr_r);
		end
		else if (hour_dec)
		begin
			// no step below the first hour of the day
			if (!fmt12)
				hr_nxt = (hr_r == 8'h00) ? hr_r : bcd_dec(hr_r);
			else if (hr_r == 8'h12 && pm_r)
			begin
				hr_nxt = 8'h11;
				pm_nxt = 1'b0;
			end
			else if (hr_r == 8'h01)
				hr_nxt = 8'h12;
			else if (hr_r != 8'h12)
				hr_nxt = bcd_dec(hr_r);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{pm_r, hr_r[5:0], min_r[6:0], sec_r[6:0]} <= {RST_TIME[22:16], RST_TIME[14:8], RST_TIME[6:0]};
			{yr_r, wd_r, mon_r[4:0], day_r[5:0]} <= {RST_DATE[23:8], RST_DATE[5:0]};
			{hr_r[7:6], min_r[7], sec_r[7], mon_r[7:5], day_r[7:6]} <= 9'h000;
		end
		else if (load)
		begin
			sec_r <= {1'b0, load_time[6:0]};
			min_r <= {1'b0, load_time[14:8]};
			hr_r <= {2'h0, load_time[21:16]};
			pm_r <= load_time[22];
			day_r <= {2'h0, load_date[5:0]};
			mon_r <= {3'h0, load_date[12:8]};
			wd_r <= load_date[15:13];
			yr_r <= load_date[23:16];
		end
		else
		begin
			sec_r <= sec_nxt;
			min_r <= min_nxt;
			hr_r <= hr_nxt;
			pm_r <= pm_nxt;
			wd_r <= wd_nxt;
			day_r <= day_nxt;
			mon_r <= mon_nxt;
			yr_r <= yr_nxt;
		end
	end

	// digits leave the block exactly as counted
	assign live_time = {pm_r, hr_r[5:0], 1'b0, min_r[6:0], 1'b0, sec_r[6:0]};
	assign live_date = {yr_r, wd_r, mon_r[4:0], 2'h0, day_r[5:0]};

	a_sec_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !load && sec_r == 8'h59 |=> sec_r == 8'h00) else $error("seconds did not wrap");
	a_day_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !load && sec_r == 8'h59 && min_r == 8'h59 && last_hour
		&& day_r == month_len(mon_r, yr_r) |=> day_r == 8'h01) else $error("day did not roll");
endmodule

/* hw/bcdcal_top.sv */
// Purpose: bcd calendar core with key protection and init handshake
// Assumes: rtc sources arrive as pins, slow against aclk (25 mhz)
// Notes: rtc edges are found by oversampling, so sources must stay well below aclk/2
// Operation
// - time and date held as bcd digits
// - day rolls over by month length
// - software steps hour for daylight saving
// - sub-second reads sync counter, writes ignored
// - keys 0xca then 0x53 unlock writes
// - key 0xff locks registers again
// - init request halts the calendar
// - init flag rises two rtc edges later
// - reset dividers give 1 hz from 32768
// - time and date writes only in init
// - hour format bit: 0 is 24h, 1 is 12h
// - exit loads values, restarts after four edges
// - two-bit select picks one of three sources
// - tick is rtc over both divider products
// - async divider is seven bits
// - sync divider is fifteen bits
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module bcdcal_top
	import bcdcal_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [bcdcal_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bcdcal_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic low_speed_crystal,
	input wire logic low_speed_internal_osc,
	input wire logic divided_high_speed_clock,
	output logic calendar_tick,
	output logic init_active_flag
);
	import bcdcal_pkg::*;

	// ****************************************
	// rtc kernel clock pickup
	// ****************************************
	logic [2:0] src_pins;
	logic [2:0] src_s1_r, src_s2_r;
	logic [1:0] rtc_clock_select_r;
	logic rtc_kernel_clock, rtc_prev_r, rtc_edge;

	assign src_pins = {divided_high_speed_clock, low_speed_internal_osc, low_speed_crystal};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					src_s1_r[gi] <= 1'b0;
					src_s2_r[gi] <= 1'b0;
				end
				else
				begin
					src_s1_r[gi] <= src_pins[gi];
					src_s2_r[gi] <= src_s1_r[gi];
				end
			end
		end
	endgenerate

	always_comb
	begin
		// select 00 leaves the calendar without a clock
		case (rtc_clock_select_r)
			CKSEL_CRYSTAL: rtc_kernel_clock = src_s2_r[0];
			CKSEL_INT_OSC: rtc_kernel_clock = src_s2_r[1];
			CKSEL_EXT_DIV: rtc_kernel_clock = src_s2_r[2];
			default: rtc_kernel_clock = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rtc_prev_r <= 1'b0;
		else
			rtc_prev_r <= rtc_kernel_clock;
	end

	assign rtc_edge = rtc_kernel_clock & ~rtc_prev_r;

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_held_r, w_held_r, bvalid_r, rvalid_r, wr_fire, wr_err;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r, wmask, rd_val;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic rd_err;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ****************************************
	// write decode and key protection
	// ****************************************
	bcdcal_key_st_t key_st_r;
	bcdcal_init_st_t st_r, st_nxt;
	logic wr_key, wr_ctrl, wr_isr, wr_prer, wr_time, wr_date, unlocked, in_init;
	logic hour_format_sel_r, init_req_r, dst_inc_r, dst_dec_r;
	logic [6:0] async_div_r, async_cnt_r;
	logic [14:0] sync_div_r, sync_cnt_r;
	logic [TIME_W-1:0] time_sh_r, live_time;
	logic [DATE_W-1:0] date_sh_r, live_date;
	logic [31:0] ctrl_m, prer_m;

	assign unlocked = key_st_r == KEY_OPEN;
	assign in_init = st_r == ST_INIT;

	always_comb
	begin
		wr_key = 1'b0;
		wr_ctrl = 1'b0;
		wr_isr = 1'b0;
		wr_prer = 1'b0;
		wr_time = 1'b0;
		wr_date = 1'b0;
		wr_err = 1'b0;
		if (awaddr_r == ADDR_WPR)
			wr_key = wr_fire && wstrb_r[0];
		else if (awaddr_r == ADDR_CTRL)
			wr_ctrl = wr_fire && unlocked;
		else if (awaddr_r == ADDR_ISR)
			wr_isr = wr_fire && unlocked && wstrb_r[0];
		else if (awaddr_r == ADDR_PRER)
			wr_prer = wr_fire && unlocked && in_init;
		else if (awaddr_r == ADDR_TIME)
			wr_time = wr_fire && unlocked && in_init;
		else if (awaddr_r == ADDR_DATE)
			wr_date = wr_fire && unlocked && in_init;
		else if (awaddr_r != ADDR_SSR) // sub-second write is accepted and dropped
			wr_err = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			key_st_r <= KEY_LOCKED;
		else if (wr_key)
		begin
			// any wrong byte, 0xff included, falls back to locked
			if (wdata_r[7:0] == KEY_FIRST && key_st_r == KEY_LOCKED)
				key_st_r <= KEY_HALF;
			else if (wdata_r[7:0] == KEY_SECOND && key_st_r == KEY_HALF)
				key_st_r <= KEY_OPEN;
			else
				key_st_r <= KEY_LOCKED;
		end
	end

	// ****************************************
	// control, prescaler and shadow registers
	// ****************************************
	always_comb ctrl_m = (ctrl_reg_val() & ~wmask) | (wdata_r & wmask);
	assign prer_m = ({9'h0, async_div_r, 1'b0, sync_div_r} & ~wmask) | (wdata_r & wmask);

	function automatic logic [31:0] ctrl_reg_val();
		logic [31:0] v;
		v = 32'h0;
		v[CTRL_HOUR12_BIT] = hour_format_sel_r;
		v[CTRL_CKSEL_LSB +: 2] = rtc_clock_select_r;
		return v;
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hour_format_sel_r <= 1'b0;
			rtc_clock_select_r <= CKSEL_CRYSTAL;
			dst_inc_r <= 1'b0;
			dst_dec_r <= 1'b0;
		end
		else
		begin
			// held calendar must not step, so only while running
			dst_inc_r <= wr_ctrl && ctrl_m[CTRL_ADD1H_BIT] && st_nxt == ST_RUN;
			dst_dec_r <= wr_ctrl && ctrl_m[CTRL_SUB1H_BIT] && st_nxt == ST_RUN;
			if (wr_ctrl)
			begin
				hour_format_sel_r <= ctrl_m[CTRL_HOUR12_BIT];
				rtc_clock_select_r <= ctrl_m[CTRL_CKSEL_LSB +: 2];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			init_req_r <= 1'b0;
		else if (wr_isr)
			init_req_r <= wdata_r[ISR_INIT_BIT];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			async_div_r <= RST_ASYNC_DIV;
			sync_div_r <= RST_SYNC_DIV;
		end
		else if (wr_prer)
		begin
			// two writes in a row allowed, each replaces the fields in its strobed bytes
			async_div_r <= prer_m[PRER_ASYNC_LSB +: 7];
			sync_div_r <= prer_m[14:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			time_sh_r <= RST_TIME;
			date_sh_r <= RST_DATE;
		end
		else if (st_r == ST_ENTER && st_nxt == ST_INIT)
		begin
			// start from the live values so a time-only update keeps the date
			time_sh_r <= live_time;
			date_sh_r <= live_date;
		end
		else
		begin
			if (wr_time)
				time_sh_r <= wdata_r[TIME_W-1:0];
			if (wr_date)
				date_sh_r <= wdata_r[DATE_W-1:0];
		end
	end

	// ****************************************
	// init handshake
	// ****************************************
	logic [2:0] edge_cnt_r;
	logic cal_load, tick_now;

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_RUN: if (init_req_r) st_nxt = ST_ENTER;
			ST_ENTER:
				if (!init_req_r)
					st_nxt = ST_RUN;
				else if (rtc_edge && edge_cnt_r == ENTER_EDGES - 3'h1)
					st_nxt = ST_INIT;
			ST_INIT: if (!init_req_r) st_nxt = ST_EXIT;
			ST_EXIT: if (rtc_edge && edge_cnt_r == EXIT_EDGES - 3'h1) st_nxt = ST_RUN;
			default: st_nxt = ST_RUN;
		endcase
	end

	assign cal_load = st_r == ST_EXIT && st_nxt == ST_RUN;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= ST_RUN;
			edge_cnt_r <= 3'h0;
			init_active_flag <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			init_active_flag <= st_nxt == ST_INIT;
			if (st_nxt != st_r)
				edge_cnt_r <= 3'h0;
			else if (rtc_edge)
				edge_cnt_r <= edge_cnt_r + 3'h1;
		end
	end

	// ****************************************
	// prescalers
	// ****************************************
	assign tick_now = st_r == ST_RUN && rtc_edge && async_cnt_r == 7'h0 && sync_cnt_r == 15'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			async_cnt_r <= RST_ASYNC_DIV;
			sync_cnt_r <= RST_SYNC_DIV;
		end
		else if (cal_load)
		begin
			async_cnt_r <= async_div_r;
			sync_cnt_r <= sync_div_r;
		end
		else if (st_r == ST_RUN && rtc_edge)
		begin
			// divide by (a+1) then by (s+1)
			if (async_cnt_r == 7'h0)
			begin
				async_cnt_r <= async_div_r;
				sync_cnt_r <= (sync_cnt_r == 15'h0) ? sync_div_r : sync_cnt_r - 15'h1;
			end
			else
				async_cnt_r <= async_cnt_r - 7'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			calendar_tick <= 1'b0;
		else
			calendar_tick <= tick_now;
	end

	bcdcal_counter u_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick_now),
		.load(cal_load),
		.load_time(time_sh_r),
		.load_date(date_sh_r),
		.fmt12(hour_format_sel_r),
		.hour_inc(dst_inc_r),
		.hour_dec(dst_dec_r),
		.live_time(live_time),
		.live_date(live_date)
	);

	// ****************************************
	// read path
	// ****************************************
	always_comb
	begin
		rd_val = 32'h0;
		rd_err = 1'b0;
		if (s_axi_araddr == ADDR_TIME)
			rd_val = {9'h0, in_init ? time_sh_r : live_time};
		else if (s_axi_araddr == ADDR_DATE)
			rd_val = {8'h0, in_init ? date_sh_r : live_date};
		else if (s_axi_araddr == ADDR_CTRL)
			rd_val = ctrl_reg_val();
		else if (s_axi_araddr == ADDR_ISR)
			rd_val = {24'h0, init_req_r, init_active_flag, 6'h0};
		else if (s_axi_araddr == ADDR_PRER)
			rd_val = {9'h0, async_div_r, 1'b0, sync_div_r};
		else if (s_axi_araddr == ADDR_SSR)
			rd_val = {17'h0, sync_cnt_r};
		else if (s_axi_araddr != ADDR_WPR)
			rd_err = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ****************************************
	// checks
	// ****************************************
	sequence s_key_second;
		wr_key && wdata_r[7:0] == KEY_SECOND && key_st_r == KEY_HALF;
	endsequence
	sequence s_exit_last;
		st_r == ST_EXIT && rtc_edge && edge_cnt_r == EXIT_EDGES - 3'h1;
	endsequence

	a_key_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
		s_key_second |=> unlocked) else $error("second key did not unlock");
	a_locked_prer: assert property (@(posedge aclk) disable iff (!aresetn)
		!unlocked |=> $stable(async_div_r) && $stable(sync_div_r)) else $error("locked divider changed");
	a_key_relock: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_key && wdata_r[7:0] == KEY_RELOCK |=> !unlocked) else $error("relock key ignored");
	a_init_halt: assert property (@(posedge aclk) disable iff (!aresetn)
		in_init |=> $stable(live_time) && $stable(sync_cnt_r)) else $error("calendar ran in init");
	a_flag_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == ST_ENTER && init_req_r && rtc_edge && edge_cnt_r == ENTER_EDGES - 3'h1
		|=> init_active_flag && in_init) else $error("init flag late");
	a_exit_load: assert property (@(posedge aclk) disable iff (!aresetn)
		s_exit_last |=> st_r == ST_RUN && live_time == $past(time_sh_r)
		&& !init_active_flag) else $error("exit did not load");
	a_shadow_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == ST_RUN && st_nxt == ST_RUN |=> $stable(time_sh_r) && $stable(date_sh_r))
		else $error("shadow written outside init");
	a_ssr_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_SSR
		|=> s_axi_rvalid && s_axi_rdata == {17'h0, $past(sync_cnt_r)}) else $error("bad sub-second");
	a_tick_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		calendar_tick |-> $past(async_cnt_r) == 7'h0 && $past(sync_cnt_r) == 15'h0
		&& sync_cnt_r == sync_div_r) else $error("tick without carry");
	a_reset_div: assert property (@(posedge aclk)
		$rose(aresetn) |-> async_div_r == RST_ASYNC_DIV && sync_div_r == RST_SYNC_DIV)
		else $error("bad reset dividers");
endmodule
